// *** logic/pwm_pkg.sv ***
// Shared register map, field layout, reset values and timing for the PWM.
package pwm_pkg;
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_TIMEBASE_COUNTER = 8'h11;
  localparam logic [7:0] IDX_TIMEBASE_CONTROL = 8'h12;
  localparam logic [7:0] IDX_DUTY_PENDING_HIGH = 8'h15;
  localparam logic [7:0] IDX_DUTY_ACTIVE_HIGH = 8'h16;
  localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
  localparam int ADDR_W = 10;

  localparam logic [7:0] RST_TIMEBASE_COUNTER = 8'h00;
  localparam logic [6:0] RST_TIMEBASE_CONTROL = 7'h00;
  localparam logic [5:0] RST_UNIT_CONTROL = 6'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
  localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'h00;

  // Timebase control fields.
  localparam int TB_PRESCALE_LSB = 0;
  localparam int TB_RUN_BIT = 2;
  localparam int TB_POSTSCALE_LSB = 3;
  // Unit control fields, and the pin's bit in the direction register.
  localparam int UC_MODE_LSB = 0;
  localparam int UC_DUTY_LOW_LSB = 4;
  localparam logic [1:0] MODE_PWM_UPPER = 2'b11;
  localparam int PIN_DIR_BIT = 2;

  // Quarter-cycle phases per instruction cycle.
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// *** logic/prescale_if.sv ***
// Carrier between the timebase core and its prescaler.
`timescale 1ns/1ps
interface prescale_if;
  logic run;
  logic [1:0] select;
  logic tick;
  logic [1:0] low_bits;
  modport ctrl (output run, output select, input tick, input low_bits);
  modport div (input run, input select, output tick, output low_bits);
endinterface

// *** logic/timebase_prescaler.sv ***
// Quarter-cycle phase plus 1/4/16 prescaler producing the count enable.
`timescale 1ns/1ps
module timebase_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  prescale_if.div ps
);
  logic [1:0] phase_q, phase_d;
  logic [3:0] pre_q, pre_d;
  logic last_pre;

  always_comb begin
    // Each clock stands for one oscillator period.
    phase_d = phase_q + 2'h1;
    pre_d = pre_q;
    if (!ps.run) begin
      phase_d = 2'h0;
      pre_d = 4'h0;
    end else if (phase_q == 2'h3) begin
      pre_d = last_pre ? 4'h0 : pre_q + 4'h1;
    end
  end

  always_comb begin
    case (ps.select)
      2'b00: last_pre = 1'b1; // see R13
      2'b01: last_pre = (pre_q == 4'h3);
      default: last_pre = (pre_q == 4'hF);
    endcase
  end

  // Counter steps once per instruction cycle after the prescale.
  assign ps.tick = ps.run && phase_q == 2'h3 && last_pre; // see R17
  // Two extra resolution bits: phase at ratio 1, prescaler bits otherwise.
  always_comb begin
    case (ps.select)
      2'b00: ps.low_bits = phase_q; // see R10
      2'b01: ps.low_bits = pre_q[1:0];
      default: ps.low_bits = pre_q[3:2];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 2'h0;
      pre_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      pre_q <= pre_d;
    end
  end
endmodule

// *** logic/pwm_timebase.sv ***
// PWM with 8-bit timebase, double-buffered duty and AXI4-Lite registers.
//
// Function
// R01 - Period is (limit+1)*4*oscillator*prescale.
// R02 - Count equal to limit restarts at zero.
// R03 - Restart sets pin unless duty is zero.
// R04 - Restart loads pending duty into active shadow.
// R05 - Postscaler never alters the PWM period.
// R06 - Duty is ten bits: high byte, control 5:4.
// R07 - Duty writes take effect at next restart.
// R08 - Active shadow read-only in PWM mode.
// R09 - Shadow plus 2-bit latch double buffers duty.
// R10 - Pin clears when duty matches extended count.
// R11 - Duty beyond period keeps pin high.
// R12 - Resolution is log2(fosc/fpwm), max ten bits.
// R13 - Prescale ratios 1, 4 and 16.
// R14 - Software configures period, duty, direction, timer, mode.
// R15 - Zeroing unit control forces output latch low.
// R16 - Upper two mode bits set select PWM.
// R17 - Count advances per instruction cycle over prescale.
// R18 - High time is duty*oscillator*prescale.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pwm_timebase (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pwm_output_pin,
  output logic pwm_output_oe
);
  prescale_if ps ();
  timebase_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .ps(ps)
  );

  logic [7:0] timebase_count_q, timebase_count_d;
  logic [6:0] tb_ctrl_q, tb_ctrl_d;
  logic [7:0] duty_write_low_q, duty_write_low_d;
  logic [7:0] duty_active_shadow_q, duty_active_shadow_d;
  logic [1:0] duty_latch_q, duty_latch_d;
  logic [5:0] unit_ctrl_q, unit_ctrl_d;
  logic [7:0] period_q, period_d;
  logic [7:0] port_c_direction_q, port_c_direction_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;

  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic pwm_mode, restart, do_write, wr_ok, rd_ok;
  logic [9:0] duty_active, count_ext;
  logic [7:0] wr_idx, rd_idx, wbyte;
  localparam int ADDR_W_L = pwm_pkg::ADDR_W;
  // Marks the clock right after a restart, when the new duty is in place.
  logic restart_q, restart_d;

  assign pwm_mode = unit_ctrl_q[pwm_pkg::UC_MODE_LSB+3 -: 2]
    == pwm_pkg::MODE_PWM_UPPER; // see R16
  assign ps.run = tb_ctrl_q[pwm_pkg::TB_RUN_BIT];
  assign ps.select = tb_ctrl_q[pwm_pkg::TB_PRESCALE_LSB +: 2]; // see R13
  // The postscale bits are stored only; they feed nothing here. see R05
  assign restart = ps.tick && timebase_count_q == period_q; // see R02 R01
  assign duty_active = {duty_active_shadow_q, duty_latch_q}; // see R09
  // Ten compare bits bound the duty resolution. see R12
  assign count_ext = {timebase_count_q, ps.low_bits}; // see R10

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = awaddr_q[ADDR_W_L-1:2];
  assign rd_idx = s_axi_araddr[ADDR_W_L-1:2];
  assign wbyte = wdata_q[7:0];
  assign wr_ok = wr_idx == pwm_pkg::IDX_TIMEBASE_COUNTER
    || wr_idx == pwm_pkg::IDX_TIMEBASE_CONTROL
    || wr_idx == pwm_pkg::IDX_DUTY_PENDING_HIGH
    || wr_idx == pwm_pkg::IDX_DUTY_ACTIVE_HIGH
    || wr_idx == pwm_pkg::IDX_UNIT_CONTROL
    || wr_idx == pwm_pkg::IDX_PERIOD_LIMIT
    || wr_idx == pwm_pkg::IDX_PORT_C_DIRECTION;

  // Write channel: address and data latch independently, in either order.
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_ok && awaddr_q[31:10] == 22'h0 ? pwm_pkg::AXI_OKAY
        : pwm_pkg::AXI_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Register and PWM state; the timer's own update beats a software write.
  always_comb begin
    timebase_count_d = timebase_count_q;
    tb_ctrl_d = tb_ctrl_q;
    duty_write_low_d = duty_write_low_q;
    duty_active_shadow_d = duty_active_shadow_q;
    duty_latch_d = duty_latch_q;
    unit_ctrl_d = unit_ctrl_q;
    period_d = period_q;
    port_c_direction_d = port_c_direction_q;
    pin_d = pin_q;
    restart_d = pwm_mode && restart;
    if (do_write && wstrb0_q && awaddr_q[31:10] == 22'h0) begin
      case (wr_idx)
        pwm_pkg::IDX_TIMEBASE_COUNTER: timebase_count_d = wbyte;
        pwm_pkg::IDX_TIMEBASE_CONTROL: tb_ctrl_d = wbyte[6:0];
        pwm_pkg::IDX_DUTY_PENDING_HIGH: duty_write_low_d = wbyte; // see R07
        pwm_pkg::IDX_DUTY_ACTIVE_HIGH: begin
          if (!pwm_mode) begin
            duty_active_shadow_d = wbyte; // see R08
          end
        end
        pwm_pkg::IDX_UNIT_CONTROL: unit_ctrl_d = wbyte[5:0]; // see R06
        pwm_pkg::IDX_PERIOD_LIMIT: period_d = wbyte;
        pwm_pkg::IDX_PORT_C_DIRECTION: port_c_direction_d = wbyte;
        default: ;
      endcase
    end
    if (ps.tick) begin
      timebase_count_d = restart ? 8'h00 : timebase_count_q + 8'h01;
    end
    if (pwm_mode && restart) begin
      // New period: load both halves of the duty buffer together.
      duty_active_shadow_d = duty_write_low_q; // see R04 R09
      duty_latch_d = unit_ctrl_q[pwm_pkg::UC_DUTY_LOW_LSB +: 2];
    end
    // The set waits one clock for the freshly loaded duty. The clear is
    // registered as well, so both edges lag alike and the high time is
    // exactly the duty count.
    if (pwm_mode && restart_q) begin
      pin_d = duty_active != 10'h000; // see R03
    end else if (pwm_mode && duty_active == count_ext) begin
      // No match ever occurs when the duty exceeds the period. see R11 R18
      pin_d = 1'b0; // see R10
    end
    if (unit_ctrl_q == 6'h00) begin
      pin_d = 1'b0; // see R15
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_ok = s_axi_araddr[31:10] == 22'h0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = pwm_pkg::AXI_OKAY;
      case (rd_idx)
        pwm_pkg::IDX_TIMEBASE_COUNTER: rdata_d = {24'h0, timebase_count_q};
        pwm_pkg::IDX_TIMEBASE_CONTROL: rdata_d = {25'h0, tb_ctrl_q};
        pwm_pkg::IDX_DUTY_PENDING_HIGH: rdata_d = {24'h0, duty_write_low_q};
        pwm_pkg::IDX_DUTY_ACTIVE_HIGH:
          rdata_d = {24'h0, duty_active_shadow_q};
        pwm_pkg::IDX_UNIT_CONTROL: rdata_d = {26'h0, unit_ctrl_q};
        pwm_pkg::IDX_PERIOD_LIMIT: rdata_d = {24'h0, period_q};
        pwm_pkg::IDX_PORT_C_DIRECTION:
          rdata_d = {24'h0, port_c_direction_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = pwm_pkg::AXI_SLVERR;
        end
      endcase
      if (!rd_ok) begin
        rdata_d = 32'h0;
        rresp_d = pwm_pkg::AXI_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Pin drives only while software has made it an output. see R14
  assign oe_d = !port_c_direction_d[pwm_pkg::PIN_DIR_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_count_q <= pwm_pkg::RST_TIMEBASE_COUNTER;
      tb_ctrl_q <= pwm_pkg::RST_TIMEBASE_CONTROL;
      duty_write_low_q <= pwm_pkg::RST_DUTY;
      duty_active_shadow_q <= pwm_pkg::RST_DUTY;
      duty_latch_q <= 2'h0;
      unit_ctrl_q <= pwm_pkg::RST_UNIT_CONTROL;
      period_q <= pwm_pkg::RST_PERIOD_LIMIT;
      port_c_direction_q <= pwm_pkg::RST_PORT_C_DIRECTION;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      restart_q <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else begin
      timebase_count_q <= timebase_count_d;
      tb_ctrl_q <= tb_ctrl_d;
      duty_write_low_q <= duty_write_low_d;
      duty_active_shadow_q <= duty_active_shadow_d;
      duty_latch_q <= duty_latch_d;
      unit_ctrl_q <= unit_ctrl_d;
      period_q <= period_d;
      port_c_direction_q <= port_c_direction_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      restart_q <= restart_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Ready is a registered "nothing held" flag, so each channel holds one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      // A request is only taken with ready high, so a valid raised while
      // ready is still low after reset is never taken twice.
      s_axi_awready <= !aw_held_d;
      s_axi_wready <= !w_held_d;
      s_axi_arready <= !rvalid_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pwm_output_pin = pin_q;
  assign pwm_output_oe = oe_q;
endmodule

// *** bench/pwm_load.sv ***
// External load model that times the pulses on the PWM pin.
`timescale 1ns/1ps
module pwm_load (
  input wire logic aclk,
  input wire logic pin,
  input wire logic oe,
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  logic lvl_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  // An undriven pin is pulled low by the load resistor.
  wire logic lvl = oe & pin;
  always @(posedge aclk) begin
    lvl_q <= lvl;
    cnt_q <= (lvl && !lvl_q) ? 16'h0001 : cnt_q + 16'h0001;
    if (lvl && !lvl_q) per_len <= cnt_q;
    if (!lvl && lvl_q) hi_len <= cnt_q;
  end
endmodule

// *** bench/pwm_timebase_checker.sv ***
// Concurrent checks on the PWM block's bus handshakes and output pin.
`timescale 1ns/1ps
module pwm_timebase_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_output_pin,
  input wire logic pwm_output_oe
);
  logic [31:0] aw_q;
  logic [31:0] wd_q;
  logic [11:0] gap_q;
  logic pin_q;
  logic seen_q;
  wire logic wr_done = s_axi_bvalid && s_axi_bready;
  wire logic rise = pwm_output_pin && !pin_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
    pin_q <= pwm_output_pin;
    gap_q <= rise ? 12'h001 : gap_q + 12'h001;
    // Any write may retime the next restart, so spacing is measured anew.
    seen_q <= aresetn && !wr_done && (seen_q || rise);
  end
  a_rise_spacing: assert property (
    rise && seen_q |-> gap_q[1:0] == 2'b00)
    else $error("Restarts not whole instruction cycles apart");
  a_zero_ctrl_low: assert property (
    wr_done && aw_q[9:2] == pwm_pkg::IDX_UNIT_CONTROL && wd_q[7:0] == 8'h00
    |=> (!pwm_output_pin) [*3])
    else $error("Pin not forced low by cleared unit control");
  a_dir_to_oe: assert property (
    wr_done && aw_q[9:2] == pwm_pkg::IDX_PORT_C_DIRECTION
    |-> ##2 pwm_output_oe == !wd_q[pwm_pkg::PIN_DIR_BIT])
    else $error("Output enable does not follow direction bit");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[0:8] s_axi_bvalid)
    else $error("Write got no response");
  a_one_bresp: assert property (wr_done |=> !s_axi_bvalid)
    else $error("Second write response");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late");
  a_one_rresp: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Second read response");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read data bits not zero");
  c_restart: cover property (rise && seen_q);
  c_ctrl_write: cover property (
    wr_done && aw_q[9:2] == pwm_pkg::IDX_UNIT_CONTROL);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pwm_timebase pwm_timebase_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwm_output_pin(pwm_output_pin),
  .pwm_output_oe(pwm_output_oe));

// *** bench/pwm_timebase_test.sv ***
// Register-level testbench for the PWM block with a timed load.
`timescale 1ns/1ps
module pwm_timebase_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic pwm_output_pin, pwm_output_oe;
  logic [15:0] hi_len, per_len;
  int n_mismatch = 0;
  int check_count = 0;
  int ratio;
  localparam logic [7:0] RIDX [6] = '{pwm_pkg::IDX_TIMEBASE_COUNTER,
    pwm_pkg::IDX_TIMEBASE_CONTROL, pwm_pkg::IDX_UNIT_CONTROL,
    pwm_pkg::IDX_PERIOD_LIMIT, pwm_pkg::IDX_PORT_C_DIRECTION,
    pwm_pkg::IDX_DUTY_PENDING_HIGH};
  localparam logic [7:0] RVAL [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
    8'h00};
  always #20 aclk = ~aclk;
  pwm_timebase i_dut (.*);
  pwm_load i_load (.aclk(aclk), .pin(pwm_output_pin), .oe(pwm_output_oe),
    .hi_len(hi_len), .per_len(per_len));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(logic [7:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic hold(logic v);
    repeat (20) begin
      @(posedge aclk);
      chk(32'(pwm_output_pin), 32'(v));
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdr(RIDX[i]);
      chk(rd, {24'h0, RVAL[i]});
    end
    rdr(8'h00);
    chk({rd[29:0], rsp}, {30'h0, pwm_pkg::AXI_SLVERR});
    wr(8'h00, 8'h5A);
    chk(32'(rsp), 32'(pwm_pkg::AXI_SLVERR));
    wr(pwm_pkg::IDX_PERIOD_LIMIT, 8'h03);
    wr(pwm_pkg::IDX_DUTY_PENDING_HIGH, 8'h02);
    wr(pwm_pkg::IDX_PORT_C_DIRECTION, 8'hFB);
    repeat (2) @(posedge aclk);
    chk(32'(pwm_output_oe), 32'h1);
    // Duty is 10 steps of oscillator times prescale, period limit 3.
    for (int s = 0; s < 3; s++) begin
      ratio = 1 << (2 * s);
      wr(pwm_pkg::IDX_TIMEBASE_CONTROL,
        {1'b0, 4'(5 * s), 1'b1, 2'(s)});
      wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h2C | 8'(s));
      repeat (48 * ratio + 8) @(posedge aclk);
      chk(32'(per_len), 32'(16 * ratio));
      chk(32'(hi_len), 32'(10 * ratio));
    end
    wr(pwm_pkg::IDX_TIMEBASE_CONTROL, 8'h00);
    rdr(pwm_pkg::IDX_DUTY_ACTIVE_HIGH);
    chk(rd, 32'h2);
    wr(pwm_pkg::IDX_DUTY_PENDING_HIGH, 8'h05);
    wr(pwm_pkg::IDX_DUTY_ACTIVE_HIGH, 8'h33);
    rdr(pwm_pkg::IDX_DUTY_ACTIVE_HIGH);
    chk(rd, 32'h2);
    wr(pwm_pkg::IDX_TIMEBASE_CONTROL, 8'h04);
    repeat (56) @(posedge aclk);
    rdr(pwm_pkg::IDX_DUTY_ACTIVE_HIGH);
    chk(rd, 32'h5);
    rdr(pwm_pkg::IDX_TIMEBASE_COUNTER);
    chk(32'(rd <= 32'h3), 32'h1);
    hold(1'b1);
    wr(pwm_pkg::IDX_DUTY_PENDING_HIGH, 8'h00);
    wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h0C);
    repeat (40) @(posedge aclk);
    hold(1'b0);
    wr(pwm_pkg::IDX_DUTY_PENDING_HIGH, 8'h02);
    wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h2C);
    repeat (40) @(posedge aclk);
    wr(pwm_pkg::IDX_UNIT_CONTROL, 8'h00);
    hold(1'b0);
    print_verdict();
  end
endmodule
